// ===== usb_link_pkg.sv
// shared constants for the usb link status and transceiver control block
package usb_link_pkg;
  // register byte addresses (apb, one aligned word each)
  localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_EVENT_ENABLES = 8'h04;
  localparam logic [7:0] ADDR_CONFIG        = 8'h08;
  localparam logic [7:0] ADDR_CONTROL       = 8'h0c;
  localparam logic [7:0] ADDR_ERROR_ENABLES = 8'h10;
  localparam logic [7:0] ADDR_DEVICE_ADDR   = 8'h14;
  localparam logic [7:0] ADDR_XFER_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_STATUS        = 8'h1c;
  // event flag positions
  localparam int FLAG_BUS_RESET   = 0;
  localparam int FLAG_ERROR       = 1;
  localparam int FLAG_ACTIVITY    = 2;
  localparam int FLAG_XFER_DONE   = 3;
  localparam int FLAG_IDLE        = 4;
  localparam int FLAG_STALL       = 5;
  localparam int FLAG_FRAME_START = 6;
  localparam logic [7:0] EVENT_IMPL_MASK = 8'h7f;
  // config register fields
  localparam int CFG_PINGPONG_LO  = 0;
  localparam int CFG_EXT_XCVR     = 2;
  localparam int CFG_FULL_SPEED   = 3;
  localparam int CFG_PULLUP_EN    = 4;
  localparam int CFG_OE_MON       = 6;
  localparam int CFG_EYE_TEST     = 7;
  // control register fields
  localparam int CTL_ENABLE       = 0;
  localparam int CTL_SUSPEND      = 1;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // timing: idle detect
  localparam int CLK_HZ           = 25_000_000;
  localparam int IDLE_TIME_US     = 3000;
  localparam int IDLE_CYCLES      = (CLK_HZ / 1_000_000) * IDLE_TIME_US;
  // transaction status fifo
  localparam int XFER_FIFO_DEPTH  = 4;
  // bus encodings on the transceiver lines {plus,minus}
  localparam logic [1:0] LINE_SE0  = 2'h0;
  localparam logic [1:0] LINE_DIF0 = 2'h1;
  localparam logic [1:0] LINE_DIF1 = 2'h2;
  localparam logic [1:0] LINE_ILL  = 2'h3;
endpackage

// ===== sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== usb_link_ctl.sv
// usb link status flags, transceiver encode/decode and config control
`timescale 1ns/1ps
`default_nettype none
// How it works
// - encode tx lines; never drive both high
// - decode rx lines into bus state
// - drive output enable low while transmitting
// - pull-ups on only when config bit 4
// - two-bit ping-pong select from config
// - oe monitor when external xcvr or bit 6
// - eye test sends endless j-k pattern
// - per-flag enables; flags ored into irq
// - flags except error sticky until written zero; settable
// - suspend stops engine events except activity
// - frame-start token sets bit 6
// - clearing done flag advances status fifo
// - line activity sets bit 2, even suspended
// - error flag read-only, from enabled errors
// - bus reset sets bit 0, clears address
module usb_link_ctl #(
  parameter int IDLE_COUNT = usb_link_pkg::IDLE_CYCLES,
  parameter int FIFO_DEPTH = usb_link_pkg::XFER_FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rx_plus_in,
  input  wire logic        rx_minus_in,
  output var  logic        tx_plus_out,
  output var  logic        tx_minus_out,
  output var  logic        xcvr_out_enable_n,
  output var  logic        pullup_enable,
  output var  logic        oe_monitor,
  output var  logic [1:0]  pingpong_sel,
  output var  logic        engine_clk_en,
  input  wire logic        sie_tx_active,
  input  wire logic [1:0]  sie_tx_line,
  input  wire logic        sie_sof_rx,
  input  wire logic        sie_stall_sent,
  input  wire logic        sie_xfer_done,
  input  wire logic [7:0]  sie_xfer_status,
  input  wire logic        sie_bus_reset,
  input  wire logic [7:0]  sie_errors,
  output var  logic        usb_irq
);
  import usb_link_pkg::*;

  typedef enum logic [1:0] {LS_SE0, LS_LOW_SPEED, LS_HIGH_SPEED, LS_ERROR} line_state_e;

  logic [7:0]  usb_event_flags_r;
  logic [7:0]  usb_event_enables_r;
  logic [7:0]  usb_config_reg_r;
  logic [7:0]  usb_control_reg_r;
  logic [7:0]  error_enables_r;
  logic [6:0]  device_addr_reg_r;
  logic [1:0]  rx_sync;
  logic [1:0]  rx_prev_r;
  line_state_e line_state;
  logic        wr_en;
  logic        rd_en;
  logic        suspended;
  logic        eng_on;
  logic        eye_on;
  logic        eye_phase_r;
  logic        activity;
  logic [31:0] idle_cnt_r;
  logic        idle_hit;
  logic        idle_done_r;
  logic [7:0]  fifo_mem_r [FIFO_DEPTH];
  logic [$clog2(FIFO_DEPTH)-1:0] fifo_rd_r;
  logic [$clog2(FIFO_DEPTH)-1:0] fifo_wr_r;
  logic [$clog2(FIFO_DEPTH):0]   fifo_cnt_r;
  logic        fifo_push;
  logic        fifo_pop;
  logic        done_cleared;
  logic        done_more;
  logic [7:0]  flag_set;
  logic [7:0]  flags_nxt;
  logic [1:0]  tx_line;

  // receive pins come from outside the clock domain
  // logic reads the lines only through rx_sync, never the raw pins
  sync2 #(.W(2)) u_rx_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({rx_plus_in, rx_minus_in}),
    .q       (rx_sync)
  );

  // apb: zero-wait slave
  // pready tied high, so a transfer ends at its first access edge
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;

  // line state decode
  // both lines high is no legal bus state, reported as an error
  always_comb begin
    case (rx_sync)
      LINE_SE0:  line_state = LS_SE0;
      LINE_DIF0: line_state = LS_LOW_SPEED;
      LINE_DIF1: line_state = LS_HIGH_SPEED;
      default:   line_state = LS_ERROR;
    endcase
  end

  assign eng_on    = usb_control_reg_r[CTL_ENABLE];
  assign suspended = usb_control_reg_r[CTL_SUSPEND];
  assign engine_clk_en = eng_on && !suspended;
  assign eye_on    = usb_config_reg_r[CFG_EYE_TEST] && eng_on;

  // any change on the lines counts as activity, sampled even in suspend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_r <= 2'h0;
    end else begin
      rx_prev_r <= rx_sync;
    end
  end
  assign activity = eng_on && (rx_prev_r != rx_sync);

  // idle timer: idle is either differential state held steady, whatever the speed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r  <= '0;
      idle_done_r <= 1'b0;
    end else if (!engine_clk_en || activity || line_state == LS_SE0
                 || line_state == LS_ERROR) begin
      idle_cnt_r  <= '0;
      idle_done_r <= 1'b0;
    end else if (idle_cnt_r < 32'(IDLE_COUNT - 1)) begin
      idle_cnt_r <= idle_cnt_r + 32'd1;
    end else begin
      idle_done_r <= 1'b1;
    end
  end
  // one pulse per idle stretch, held by idle_done_r
  assign idle_hit = engine_clk_en && !idle_done_r && !activity
                    && (idle_cnt_r == 32'(IDLE_COUNT - 1))
                    && line_state != LS_SE0 && line_state != LS_ERROR;

  // hardware set sources; engine events dropped in suspend
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLAG_FRAME_START] = engine_clk_en && sie_sof_rx;
    flag_set[FLAG_STALL]       = engine_clk_en && sie_stall_sent;
    flag_set[FLAG_IDLE]        = idle_hit;
    flag_set[FLAG_XFER_DONE]   = done_more;
    flag_set[FLAG_ACTIVITY]    = activity;
    flag_set[FLAG_ERROR]       = engine_clk_en && |(sie_errors & error_enables_r);
    flag_set[FLAG_BUS_RESET]   = engine_clk_en && sie_bus_reset;
  end

  // software write: zero clears, one sets; error bit not writable
  always_comb begin
    flags_nxt = usb_event_flags_r;
    if (wr_en && paddr == ADDR_EVENT_FLAGS) begin
      flags_nxt = pwdata[7:0];
      flags_nxt[FLAG_ERROR] = usb_event_flags_r[FLAG_ERROR];
    end
    flags_nxt = (flags_nxt | flag_set) & EVENT_IMPL_MASK;
  end

  // sticky flags; set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_event_flags_r <= RESET_BYTE;
    end else begin
      usb_event_flags_r <= flags_nxt;
    end
  end

  // done flag cleared by software pops the status fifo
  assign done_cleared = wr_en && paddr == ADDR_EVENT_FLAGS
                        && usb_event_flags_r[FLAG_XFER_DONE]
                        && !pwdata[FLAG_XFER_DONE];
  assign fifo_pop  = done_cleared && fifo_cnt_r != '0;
  // push lost when full; engine should hold off
  assign fifo_push = engine_clk_en && sie_xfer_done
                     && (fifo_cnt_r != ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH));
  // done flag re-arms only while an entry is left after this cycle's pop;
  // re-arming on the old count would make the last clear ineffective
  localparam logic [$clog2(FIFO_DEPTH):0] CNT_ONE = ($clog2(FIFO_DEPTH)+1)'(1);
  assign done_more = fifo_push
                     || (fifo_pop ? (fifo_cnt_r > CNT_ONE) : (fifo_cnt_r != '0));

  // transaction status fifo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_rd_r  <= '0;
      fifo_wr_r  <= '0;
      fifo_cnt_r <= '0;
    end else begin
      if (fifo_push) begin
        fifo_wr_r <= fifo_wr_r + 1'b1;
      end
      if (fifo_pop) begin
        fifo_rd_r <= fifo_rd_r + 1'b1;
      end
      if (fifo_push && !fifo_pop) begin
        fifo_cnt_r <= fifo_cnt_r + 1'b1;
      end else if (fifo_pop && !fifo_push) begin
        fifo_cnt_r <= fifo_cnt_r - 1'b1;
      end
    end
  end

  // fifo storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem_r[i] <= 8'h00;
      end
    end else if (fifo_push) begin
      fifo_mem_r[fifo_wr_r] <= sie_xfer_status;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_event_enables_r <= RESET_BYTE;
      usb_config_reg_r    <= RESET_BYTE;
      usb_control_reg_r   <= RESET_BYTE;
      error_enables_r     <= RESET_BYTE;
    end else if (wr_en) begin
      if (paddr == ADDR_EVENT_ENABLES) begin
        usb_event_enables_r <= pwdata[7:0] & EVENT_IMPL_MASK;
      end else if (paddr == ADDR_CONFIG) begin
        usb_config_reg_r <= pwdata[7:0];
      end else if (paddr == ADDR_CONTROL) begin
        usb_control_reg_r <= {6'h00, pwdata[1:0]};
      end else if (paddr == ADDR_ERROR_ENABLES) begin
        error_enables_r <= pwdata[7:0];
      end
    end
  end

  // device address: bus reset clears it and wins over a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_addr_reg_r <= 7'h00;
    end else if (flag_set[FLAG_BUS_RESET]) begin
      device_addr_reg_r <= 7'h00;
    end else if (wr_en && paddr == ADDR_DEVICE_ADDR) begin
      device_addr_reg_r <= pwdata[6:0];
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      if (paddr == ADDR_EVENT_FLAGS) begin
        prdata = {24'h0, usb_event_flags_r};
      end else if (paddr == ADDR_EVENT_ENABLES) begin
        prdata = {24'h0, usb_event_enables_r};
      end else if (paddr == ADDR_CONFIG) begin
        prdata = {24'h0, usb_config_reg_r};
      end else if (paddr == ADDR_CONTROL) begin
        prdata = {24'h0, usb_control_reg_r};
      end else if (paddr == ADDR_ERROR_ENABLES) begin
        prdata = {24'h0, error_enables_r};
      end else if (paddr == ADDR_DEVICE_ADDR) begin
        prdata = {25'h0, device_addr_reg_r};
      end else if (paddr == ADDR_XFER_STATUS) begin
        prdata = {24'h0, fifo_mem_r[fifo_rd_r]};
      end else if (paddr == ADDR_STATUS) begin
        prdata = {28'h0, rx_sync, 2'(line_state)};
      end
    end
  end

  // interrupt: any flag with its enable set
  assign usb_irq = |(usb_event_flags_r & usb_event_enables_r);

  // eye pattern toggles every cycle; full speed starts on k
  // limitation: nothing guards against a live bus, software must keep off it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eye_phase_r <= 1'b0;
    end else if (eye_on) begin
      eye_phase_r <= !eye_phase_r;
    end else begin
      eye_phase_r <= 1'b0;
    end
  end

  // choose line value; eye test overrides the engine
  always_comb begin
    if (eye_on) begin
      tx_line = (eye_phase_r ^ usb_config_reg_r[CFG_FULL_SPEED]) ? LINE_DIF0
                                                                 : LINE_DIF1;
    end else if (sie_tx_active && engine_clk_en) begin
      tx_line = sie_tx_line;
    end else begin
      tx_line = LINE_DIF1;
    end
    // the illegal code is never put on the pins
    if (tx_line == LINE_ILL) begin
      tx_line = LINE_SE0;
    end
  end

  // registered pin drive keeps outputs glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_plus_out       <= 1'b0;
      tx_minus_out      <= 1'b0;
      xcvr_out_enable_n <= 1'b1;
      pullup_enable     <= 1'b0;
      oe_monitor        <= 1'b1;
      pingpong_sel      <= 2'h0;
    end else begin
      tx_plus_out       <= tx_line[1];
      tx_minus_out      <= tx_line[0];
      xcvr_out_enable_n <= !(eye_on || (sie_tx_active && engine_clk_en));
      pullup_enable     <= usb_config_reg_r[CFG_PULLUP_EN];
      pingpong_sel      <= usb_config_reg_r[CFG_PINGPONG_LO +: 2];
      if (usb_config_reg_r[CFG_EXT_XCVR] || usb_config_reg_r[CFG_OE_MON]) begin
        oe_monitor <= !(eye_on || (sie_tx_active && engine_clk_en));
      end else begin
        oe_monitor <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== usb_link_ctl_props.sv
// assertion checker for the usb link status and transceiver control block
`timescale 1ns/1ps
`default_nettype none
module usb_link_ctl_props
  import usb_link_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        tx_plus_out,
  input wire logic        tx_minus_out,
  input wire logic        xcvr_out_enable_n,
  input wire logic        pullup_enable,
  input wire logic        oe_monitor,
  input wire logic [1:0]  pingpong_sel,
  input wire logic        engine_clk_en,
  input wire logic        sie_tx_active,
  input wire logic [1:0]  sie_tx_line,
  input wire logic        sie_sof_rx,
  input wire logic        sie_stall_sent,
  input wire logic        usb_irq
);
  logic [7:0] cfg_r, ctl_r, en_r;
  logic [2:0] stab_r;
  logic       wr;
  assign wr = psel && penable && pwrite;
  // shadow of config, control and enables; stab_r counts cycles since a mode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 8'h00;
      ctl_r <= 8'h00;
      en_r <= 8'h00;
      stab_r <= 3'h0;
    end else begin
      if (wr && paddr == ADDR_CONFIG) cfg_r <= pwdata[7:0];
      if (wr && paddr == ADDR_CONTROL) ctl_r <= pwdata[7:0];
      if (wr && paddr == ADDR_EVENT_ENABLES) en_r <= pwdata[7:0];
      // outputs are registered off the config, so allow two cycles to settle
      if (wr && (paddr == ADDR_CONFIG || paddr == ADDR_CONTROL)) stab_r <= 3'h0;
      else if (stab_r != 3'h7) stab_r <= stab_r + 3'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_no_ill; !(tx_plus_out && tx_minus_out); endproperty
  a_no_ill: assert property (p_no_ill) else $error("both tx lines high");
  property p_tx_enc; sie_tx_active && engine_clk_en && !cfg_r[7] |=> !xcvr_out_enable_n
    && {tx_plus_out, tx_minus_out} == (($past(sie_tx_line) == LINE_ILL) ? LINE_SE0
    : $past(sie_tx_line)); endproperty
  a_tx_enc: assert property (p_tx_enc) else $error("tx encode or enable wrong");
  property p_cfg; stab_r >= 3'h2 |-> pullup_enable == cfg_r[4] && pingpong_sel == cfg_r[1:0];
  endproperty
  a_cfg: assert property (p_cfg) else $error("pullup or pingpong mismatch");
  property p_oe_mon; stab_r >= 3'h2 && !(cfg_r[2] || cfg_r[6]) |-> oe_monitor; endproperty
  a_oe_mon: assert property (p_oe_mon) else $error("monitor active while off");
  property p_clk_en; engine_clk_en == (ctl_r[0] && !ctl_r[1]); endproperty
  a_clk_en: assert property (p_clk_en) else $error("engine clock gate wrong");
  property p_sof_irq; sie_sof_rx && engine_clk_en && en_r[6] |=> usb_irq; endproperty
  a_sof_irq: assert property (p_sof_irq) else $error("frame start gave no irq");
  property p_susp; !engine_clk_en && !en_r[2] && (sie_sof_rx || sie_stall_sent) && !usb_irq
    && !wr |=> !usb_irq; endproperty
  a_susp: assert property (p_susp) else $error("event taken while stopped");
  property p_top0; psel && penable && !pwrite && paddr == ADDR_EVENT_FLAGS
    |-> prdata[31:7] == 25'h0; endproperty
  a_top0: assert property (p_top0) else $error("flag top bits not zero");
  property p_eye; stab_r >= 3'h4 && cfg_r[7] && ctl_r[0] |-> !xcvr_out_enable_n
    && tx_plus_out != $past(tx_plus_out) && tx_minus_out != $past(tx_minus_out); endproperty
  a_eye: assert property (p_eye) else $error("eye pattern not toggling");
  c_sof: cover property (sie_sof_rx && engine_clk_en);
  c_eye: cover property (cfg_r[7] && ctl_r[0] && stab_r == 3'h7);
  c_susp: cover property (!engine_clk_en && ctl_r[0] && sie_stall_sent);
endmodule
bind usb_link_ctl usb_link_ctl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .tx_plus_out(tx_plus_out), .tx_minus_out(tx_minus_out),
  .xcvr_out_enable_n(xcvr_out_enable_n), .pullup_enable(pullup_enable),
  .oe_monitor(oe_monitor), .pingpong_sel(pingpong_sel), .engine_clk_en(engine_clk_en),
  .sie_tx_active(sie_tx_active), .sie_tx_line(sie_tx_line), .sie_sof_rx(sie_sof_rx),
  .sie_stall_sent(sie_stall_sent), .usb_irq(usb_irq));
`default_nettype wire

// ===== xcvr_model.sv
// behavioural external transceiver with the bus behind it
`timescale 1ns/1ps
`default_nettype none
module xcvr_model (
  input  wire logic [1:0] bus_state,
  input  wire logic       tx_plus_out,
  input  wire logic       tx_minus_out,
  input  wire logic       xcvr_out_enable_n,
  output var  logic       rx_plus_in,
  output var  logic       rx_minus_in
);
  // receiver hears our own driver while enabled, else the far end's line state
  always_comb begin
    if (!xcvr_out_enable_n) begin
      {rx_plus_in, rx_minus_in} = {tx_plus_out, tx_minus_out};
    end else begin
      {rx_plus_in, rx_minus_in} = bus_state;
    end
  end
endmodule
`default_nettype wire

// ===== usb_sie_status_and_transceiver_ctl_tb_top.sv
// self-checking bench for the usb link status and transceiver control block
`timescale 1ns/1ps
`default_nettype none
module usb_sie_status_and_transceiver_ctl_tb_top;
  import usb_link_pkg::*;
  localparam int IDLE_N = 200; // short idle count keeps the run brief
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, sie_xfer_status, sie_errors;
  logic [31:0] pwdata, prdata;
  logic        rx_plus_in, rx_minus_in, tx_plus_out, tx_minus_out, usb_irq;
  logic        xcvr_out_enable_n, pullup_enable, oe_monitor, engine_clk_en;
  logic [1:0]  pingpong_sel, sie_tx_line, bus_state, v;
  logic        sie_tx_active, sie_sof_rx, sie_stall_sent, sie_xfer_done, sie_bus_reset;
  int          fails, tests_run, n;
  usb_link_ctl #(.IDLE_COUNT(IDLE_N), .FIFO_DEPTH(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_plus_in(rx_plus_in),
    .rx_minus_in(rx_minus_in), .tx_plus_out(tx_plus_out), .tx_minus_out(tx_minus_out),
    .xcvr_out_enable_n(xcvr_out_enable_n), .pullup_enable(pullup_enable),
    .oe_monitor(oe_monitor), .pingpong_sel(pingpong_sel), .engine_clk_en(engine_clk_en),
    .sie_tx_active(sie_tx_active), .sie_tx_line(sie_tx_line), .sie_sof_rx(sie_sof_rx),
    .sie_stall_sent(sie_stall_sent), .sie_xfer_done(sie_xfer_done),
    .sie_xfer_status(sie_xfer_status), .sie_bus_reset(sie_bus_reset),
    .sie_errors(sie_errors), .usb_irq(usb_irq));
  xcvr_model u_xcvr (.bus_state(bus_state), .tx_plus_out(tx_plus_out),
    .tx_minus_out(tx_minus_out), .xcvr_out_enable_n(xcvr_out_enable_n),
    .rx_plus_in(rx_plus_in), .rx_minus_in(rx_minus_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      fails++;
      summarize();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // one-cycle engine pulses {frame start, stall, done, bus reset}
  task automatic ev(input logic [3:0] m);
    {sie_sof_rx, sie_stall_sent, sie_xfer_done, sie_bus_reset} <= m;
    tick(1);
    {sie_sof_rx, sie_stall_sent, sie_xfer_done, sie_bus_reset} <= 4'h0;
    tick(2);
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sie_xfer_status, sie_errors} = '0;
    {sie_tx_active, sie_tx_line, sie_sof_rx, sie_stall_sent, sie_xfer_done} = '0;
    {sie_bus_reset, bus_state, fails, tests_run} = '0;
    tick(20);
    presetn <= 1'b1;
    tick(1);
    rd(ADDR_EVENT_FLAGS, 32'h0);
    wr(ADDR_CONFIG, 32'h12);
    tick(2);
    chk({31'h0, pullup_enable}, 32'h1);
    chk({30'h0, pingpong_sel}, 32'h2);
    chk({31'h0, oe_monitor}, 32'h1);
    wr(ADDR_CONTROL, 32'h1);
    wr(ADDR_EVENT_ENABLES, 32'h7f);
    bus_state <= LINE_DIF0;
    tick(5);
    rd(ADDR_EVENT_FLAGS, 32'h04);
    chk({31'h0, usb_irq}, 32'h1);
    rd(ADDR_STATUS, 32'h05);
    bus_state <= LINE_SE0;
    tick(5);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    rd(ADDR_EVENT_FLAGS, 32'h0);
    ev(4'h8);
    rd(ADDR_EVENT_FLAGS, 32'h40);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    ev(4'h4);
    rd(ADDR_EVENT_FLAGS, 32'h20);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    wr(ADDR_DEVICE_ADDR, 32'h55);
    ev(4'h1);
    rd(ADDR_EVENT_FLAGS, 32'h01);
    rd(ADDR_DEVICE_ADDR, 32'h0);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    // two queued transactions; clearing the done flag pops the head
    sie_xfer_status <= 8'h11;
    ev(4'h2);
    sie_xfer_status <= 8'h22;
    ev(4'h2);
    rd(ADDR_EVENT_FLAGS, 32'h08);
    rd(ADDR_XFER_STATUS, 32'h11);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    rd(ADDR_XFER_STATUS, 32'h22);
    rd(ADDR_EVENT_FLAGS, 32'h08);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    rd(ADDR_EVENT_FLAGS, 32'h0);
    wr(ADDR_EVENT_FLAGS, 32'hff);
    rd(ADDR_EVENT_FLAGS, 32'h7d);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    wr(ADDR_EVENT_ENABLES, 32'h0);
    ev(4'h8);
    chk({31'h0, usb_irq}, 32'h0);
    wr(ADDR_EVENT_ENABLES, 32'h7f);
    chk({31'h0, usb_irq}, 32'h1);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    // suspended: engine events dropped, line activity still flagged
    wr(ADDR_EVENT_ENABLES, 32'h7b);
    wr(ADDR_CONTROL, 32'h3);
    ev(4'h4);
    rd(ADDR_EVENT_FLAGS, 32'h0);
    bus_state <= LINE_DIF0;
    tick(5);
    rd(ADDR_EVENT_FLAGS, 32'h04);
    wr(ADDR_CONTROL, 32'h1);
    bus_state <= LINE_SE0;
    tick(5);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    wr(ADDR_EVENT_ENABLES, 32'h10);
    bus_state <= LINE_DIF1;
    n = 0;
    while (usb_irq !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(32'(n >= IDLE_N && n <= IDLE_N + 8), 32'h1);
    rd(ADDR_EVENT_FLAGS, 32'h14);
    rd(ADDR_STATUS, 32'h0a);
    wr(ADDR_EVENT_ENABLES, 32'h04);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    wr(ADDR_ERROR_ENABLES, 32'h1);
    sie_errors <= 8'h02;
    tick(1);
    sie_errors <= 8'h01;
    tick(1);
    sie_errors <= 8'h00;
    tick(2);
    wr(ADDR_EVENT_FLAGS, 32'h0);
    rd(ADDR_EVENT_FLAGS, 32'h02);
    wr(ADDR_CONFIG, 32'h04);
    sie_tx_line <= LINE_DIF0;
    sie_tx_active <= 1'b1;
    tick(3);
    chk({30'h0, tx_plus_out, tx_minus_out}, {30'h0, LINE_DIF0});
    chk({30'h0, xcvr_out_enable_n, oe_monitor}, 32'h0);
    sie_tx_line <= LINE_SE0;
    tick(2);
    chk({30'h0, tx_plus_out, tx_minus_out}, {30'h0, LINE_SE0});
    wr(ADDR_CONFIG, 32'h40);
    tick(2);
    chk({31'h0, oe_monitor}, 32'h0);
    wr(ADDR_CONFIG, 32'h00);
    tick(2);
    chk({31'h0, oe_monitor}, 32'h1);
    sie_tx_active <= 1'b0;
    tick(3);
    chk({31'h0, xcvr_out_enable_n}, 32'h1);
    bus_state <= LINE_ILL;
    tick(4);
    rd(ADDR_STATUS, 32'h0f);
    wr(ADDR_CONFIG, 32'h10);
    wr(ADDR_CONFIG, 32'h90);
    tick(4);
    chk({31'h0, xcvr_out_enable_n}, 32'h0);
    v = {tx_plus_out, tx_minus_out};
    tick(1);
    chk({30'h0, tx_plus_out, tx_minus_out}, {30'h0, v[0], v[1]});
    summarize();
  end
endmodule
`default_nettype wire
